//--- sbns_top.sv
// subtract-with-borrow / nibble-swap unit with its control-bus register set
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sbns_top (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [11:0] FILE_ADDR,
  output logic FILE_RE,
  input wire logic [7:0] FILE_RDATA,
  output logic FILE_WE,
  output logic [7:0] FILE_WDATA,
  output logic IDX_MODE
);
  logic ext_r;
  logic [7:0] w_r;
  logic [4:0] flags_r;
  logic [3:0] bank_r;
  logic illegal_r;
  logic start_r;
  logic [15:0] instr_r;
  logic aw_ok_r;
  logic w_ok_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic busy;
  logic done;
  logic wr_w;
  logic upd_flags;
  logic ex_illegal;
  logic [7:0] ex_result;
  logic [4:0] ex_flags;

  sbns_exec u_exec (
    .clk(REF_CLK),
    .srst(SRST),
    .ce(CE),
    .start(start_r),
    .instr(instr_r),
    .w_val(w_r),
    .flags_in(flags_r),
    .bank(bank_r),
    .ext_en(ext_r),
    .file_rdata(FILE_RDATA),
    .file_addr(FILE_ADDR),
    .file_re(FILE_RE),
    .file_we(FILE_WE),
    .file_wdata(FILE_WDATA),
    .idx_mode(IDX_MODE),
    .busy(busy),
    .done(done),
    .wr_w(wr_w),
    .upd_flags(upd_flags),
    .illegal(ex_illegal),
    .result(ex_result),
    .flags_out(ex_flags)
  );

  // write channel: address and data are caught separately, in either order
  wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID && S_AXI_WREADY;
  wire do_wr = aw_ok_r && w_ok_r && !S_AXI_BVALID;
  wire b_hs = S_AXI_BVALID && S_AXI_BREADY;
  wire sel_ctrl = (aw_addr_r == sbns_pkg::OFS_CTRL);
  wire sel_instr = (aw_addr_r == sbns_pkg::OFS_INSTR);
  wire sel_wreg = (aw_addr_r == sbns_pkg::OFS_WREG);
  wire sel_flags = (aw_addr_r == sbns_pkg::OFS_FLAGS);
  wire sel_bank = (aw_addr_r == sbns_pkg::OFS_BANK);
  wire sel_stat = (aw_addr_r == sbns_pkg::OFS_STAT);
  wire sel_res = (aw_addr_r == sbns_pkg::OFS_RESULT);
  wire wr_known = sel_ctrl || sel_instr || sel_wreg || sel_flags || sel_bank || sel_stat
                  || sel_res;
  wire b0 = do_wr && w_strb_r[0];
  // an instruction needs both low bytes; one issued while busy is dropped
  wire go = do_wr && sel_instr && (w_strb_r[1:0] == 2'h3) && !busy && !start_r;
  wire ill_clr = b0 && sel_stat && w_data_r[sbns_pkg::STAT_ILLEGAL_BIT];

  wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  // busy also spans the decode-fault cycle, so a poll never sees idle before the sticky flag
  wire stat_busy = busy || start_r || ex_illegal;
  wire [31:0] stat_word = {30'h0000_0000, illegal_r, stat_busy};
  logic [31:0] rd_word;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    if (S_AXI_ARADDR == sbns_pkg::OFS_CTRL) rd_word = {31'h0000_0000, ext_r};
    else if (S_AXI_ARADDR == sbns_pkg::OFS_INSTR) rd_word = {16'h0000, instr_r};
    else if (S_AXI_ARADDR == sbns_pkg::OFS_WREG) rd_word = {24'h00_0000, w_r};
    else if (S_AXI_ARADDR == sbns_pkg::OFS_FLAGS) rd_word = {27'h000_0000, flags_r};
    else if (S_AXI_ARADDR == sbns_pkg::OFS_BANK) rd_word = {28'h000_0000, bank_r};
    else if (S_AXI_ARADDR == sbns_pkg::OFS_STAT) rd_word = stat_word;
    else if (S_AXI_ARADDR == sbns_pkg::OFS_RESULT) rd_word = {24'h00_0000, ex_result};
    else begin
      rd_word = 32'h0000_0000;
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= sbns_pkg::RESP_OKAY;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (CE) begin
      if (aw_hs) begin
        aw_ok_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (w_hs) begin
        w_ok_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_wr) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known ? sbns_pkg::RESP_OKAY : sbns_pkg::RESP_SLVERR;
      end
      if (b_hs) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= sbns_pkg::RESP_OKAY;
    end else if (CE) begin
      if (ar_hs) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_known ? sbns_pkg::RESP_OKAY : sbns_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ext_r <= sbns_pkg::RST_EXT;
      bank_r <= sbns_pkg::RST_BANK;
      start_r <= 1'b0;
      instr_r <= 16'h0000;
    end else if (CE) begin
      start_r <= go;
      if (go) instr_r <= w_data_r[15:0];
      if (b0 && sel_ctrl) ext_r <= w_data_r[sbns_pkg::CTRL_EXT_BIT];
      if (b0 && sel_bank) bank_r <= w_data_r[3:0];
    end
  end

  // the engine's own update beats a software write in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      w_r <= sbns_pkg::RST_WREG;
    end else if (CE) begin
      if (done && wr_w) w_r <= ex_result;
      else if (b0 && sel_wreg) w_r <= w_data_r[7:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      flags_r <= sbns_pkg::RST_FLAGS;
    end else if (CE) begin
      if (done && upd_flags) flags_r <= ex_flags;
      else if (b0 && sel_flags) flags_r <= w_data_r[4:0];
    end
  end

  // a decode fault in the clearing cycle still sets the flag
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      illegal_r <= 1'b0;
    end else if (CE) begin
      if (ex_illegal) illegal_r <= 1'b1;
      else if (ill_clr) illegal_r <= 1'b0;
    end
  end
endmodule

//--- sbns_pkg.sv
// constants shared by the subtract-with-borrow / nibble-swap unit
package sbns_pkg;
  // register byte offsets on the control bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_BANK = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  // field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  // reset values
  localparam logic RST_EXT = 1'h0;
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  // opcode fields: bits 15:10 select the operation
  localparam logic [5:0] OPC_SUBB = 6'h16;
  localparam logic [5:0] OPC_SWAP = 6'h0E;
  // addressing
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} sbns_phase_t;
endpackage

//--- sbns_exec.sv
// four-phase decode and execute engine for the two file-register operations
`timescale 1ns/1ps
module sbns_exec (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  input wire logic [15:0] instr,
  input wire logic [7:0] w_val,
  input wire logic [4:0] flags_in,
  input wire logic [3:0] bank,
  input wire logic ext_en,
  input wire logic [7:0] file_rdata,
  output logic [11:0] file_addr,
  output logic file_re,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic idx_mode,
  output logic busy,
  output logic done,
  output logic wr_w,
  output logic upd_flags,
  output logic illegal,
  output logic [7:0] result,
  output logic [4:0] flags_out
);
  sbns_pkg::sbns_phase_t ph_r;
  logic [15:0] ir_r;
  logic [7:0] opnd_r;

  wire [7:0] f_adr = ir_r[7:0];
  wire bank_sel = ir_r[8];
  wire dest_file = ir_r[9];
  wire is_subb = (ir_r[15:10] == sbns_pkg::OPC_SUBB);
  wire is_swap = (ir_r[15:10] == sbns_pkg::OPC_SWAP);
  // indexed literal offset: the core adds its own base, only the offset leaves here
  wire use_idx = !bank_sel && ext_en && (f_adr <= sbns_pkg::IDX_LIMIT);
  wire [3:0] acc_bank = (f_adr < sbns_pkg::ACCESS_SPLIT) ? sbns_pkg::ACCESS_LOW_BANK :
                        sbns_pkg::ACCESS_HIGH_BANK;
  wire [3:0] eff_bank = bank_sel ? bank : acc_bank;
  wire [11:0] eff_addr = use_idx ? {4'h0, f_adr} : {eff_bank, f_adr};

  // borrow-in is the inverted carry
  wire bin = !flags_in[sbns_pkg::FLG_C];
  wire [8:0] diff = {1'b0, opnd_r} - {1'b0, w_val} - {8'h00, bin};
  wire [4:0] ndiff = {1'b0, opnd_r[3:0]} - {1'b0, w_val[3:0]} - {4'h0, bin};
  wire ovf = (opnd_r[7] != w_val[7]) && (diff[7] != opnd_r[7]);
  wire [4:0] subb_flags = {diff[7], ovf, (diff[7:0] == 8'h00), !ndiff[4], !diff[8]};
  wire [7:0] swapped = {opnd_r[3:0], opnd_r[7:4]};
  wire [7:0] res_nxt = is_subb ? diff[7:0] : swapped;

  assign busy = (ph_r != sbns_pkg::PH_IDLE);

  // one instruction cycle: Q1 decode, Q2 read, Q3 process, Q4 write
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_r <= sbns_pkg::PH_IDLE;
      ir_r <= 16'h0000;
      opnd_r <= 8'h00;
      file_addr <= 12'h000;
      file_re <= 1'b0;
      file_we <= 1'b0;
      file_wdata <= 8'h00;
      idx_mode <= 1'b0;
      done <= 1'b0;
      wr_w <= 1'b0;
      upd_flags <= 1'b0;
      illegal <= 1'b0;
      result <= 8'h00;
      flags_out <= 5'h00;
    end else if (ce) begin
      done <= 1'b0;
      wr_w <= 1'b0;
      upd_flags <= 1'b0;
      illegal <= 1'b0;
      case (ph_r)
        sbns_pkg::PH_IDLE: begin
          if (start) begin
            ir_r <= instr;
            ph_r <= sbns_pkg::PH_Q1;
          end
        end
        sbns_pkg::PH_Q1: begin
          if (is_subb || is_swap) begin
            file_addr <= eff_addr;
            idx_mode <= use_idx;
            file_re <= 1'b1;
            ph_r <= sbns_pkg::PH_Q2;
          end else begin
            illegal <= 1'b1;
            ph_r <= sbns_pkg::PH_IDLE;
          end
        end
        sbns_pkg::PH_Q2: begin
          opnd_r <= file_rdata;
          file_re <= 1'b0;
          ph_r <= sbns_pkg::PH_Q3;
        end
        sbns_pkg::PH_Q3: begin
          result <= res_nxt;
          flags_out <= is_subb ? subb_flags : flags_in;
          file_wdata <= res_nxt;
          file_we <= dest_file;
          ph_r <= sbns_pkg::PH_Q4;
        end
        sbns_pkg::PH_Q4: begin
          file_we <= 1'b0;
          done <= 1'b1;
          wr_w <= !dest_file;
          upd_flags <= is_subb;
          ph_r <= sbns_pkg::PH_IDLE;
        end
        default: ph_r <= sbns_pkg::PH_IDLE;
      endcase
    end
  end
endmodule

//--- sbns_checker.sv
// port-level assertions for the subtract and nibble-swap unit
`timescale 1ns/1ps
module sbns_checker (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic FILE_RE,
  input wire logic FILE_WE,
  input wire logic [7:0] FILE_WDATA,
  input wire logic [7:0] FILE_RDATA,
  input wire logic [11:0] FILE_ADDR,
  input wire logic IDX_MODE
);
  logic [15:0] op_r;
  logic ext_r;
  wire hs = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  wire [5:0] opc = op_r[15:10];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // mirrors only writes whose address and data land on one edge
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      op_r <= 16'h0000;
      ext_r <= 1'h0;
    end else if (hs && S_AXI_AWADDR == sbns_pkg::OFS_INSTR) begin
      op_r <= S_AXI_WDATA[15:0];
    end else if (hs && S_AXI_AWADDR == sbns_pkg::OFS_CTRL) begin
      ext_r <= S_AXI_WDATA[0];
    end
  end
  a_re_pulse: assert property (FILE_RE |=> !FILE_RE)
    else $error("file read longer than one cycle");
  a_we_after_re: assert property (FILE_RE && op_r[9] |-> ##2 FILE_WE)
    else $error("file write not two cycles after read");
  a_we_only_d: assert property (FILE_WE |-> op_r[9])
    else $error("file write with destination bit clear");
  a_re_legal: assert property (FILE_RE |-> opc == 6'h16 || opc == 6'h0E)
    else $error("file read for unknown opcode");
  a_swap_data: assert property (FILE_WE && opc == 6'h0E |->
    FILE_WDATA == {$past(FILE_RDATA[3:0], 2), $past(FILE_RDATA[7:4], 2)})
    else $error("swap result wrong");
  a_idx_mode: assert property (FILE_RE |->
    IDX_MODE == (!op_r[8] && ext_r && op_r[7:0] <= 8'h5F))
    else $error("indexed mode wrong");
  a_addr_low: assert property (FILE_RE |-> FILE_ADDR[7:0] == op_r[7:0])
    else $error("file address low byte wrong");
  a_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write channel ready during response");
  c_swap: cover property (FILE_WE && opc == 6'h0E);
  c_idx: cover property (FILE_RE && IDX_MODE);
  c_to_w: cover property (FILE_RE && !op_r[9]);
endmodule
bind sbns_top sbns_checker i_chk (.REF_CLK(REF_CLK), .SRST(SRST),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .FILE_RE(FILE_RE), .FILE_WE(FILE_WE),
  .FILE_WDATA(FILE_WDATA), .FILE_RDATA(FILE_RDATA), .FILE_ADDR(FILE_ADDR),
  .IDX_MODE(IDX_MODE));

//--- testbench.sv
// self-checking bench with a reference model of both operations
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0, srst = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0;
  logic arv = 1'h0, rry = 1'h0, d, a, ext, ri, eidx;
  logic [7:0] awa = 8'h00, ara = 8'h00, frd = 8'h00, fa, w, x, res, wd;
  logic [31:0] wdat = 32'h0000_0000, v, st;
  logic [11:0] ra, ea;
  logic [4:0] fl, nf;
  logic [3:0] bk;
  logic [5:0] opc;
  logic [1:0] r, wbr;
  wire awr, wry, bv, arr, rv, fre, fwe, idx;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] fad;
  wire [7:0] fwd;
  int fail_count = 0, num_checks = 0, nre, nwe, k, n, bo, dif, dh;
  int unsigned seed_v;
  sbns_top i_dut (.REF_CLK(clk), .SRST(srst), .CE(1'h1), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdat),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wry),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .FILE_ADDR(fad), .FILE_RE(fre), .FILE_RDATA(frd),
    .FILE_WE(fwe), .FILE_WDATA(fwd), .IDX_MODE(idx));
  initial forever #4 clk = ~clk;
  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    int t = 0;
    awa <= ad;
    wdat <= dt;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wry) wv <= 1'h0;
      t++;
    end while (!bv && t < 99);
    wbr = bresp;
    bry <= 1'h0;
    if (t >= 99) fail_count++;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int t = 0;
    ara <= ad;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      t++;
    end while (!rv && t < 99);
    dt = rdata;
    rs = rresp;
    rry <= 1'h0;
    if (t >= 99) fail_count++;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (fre) begin
      ra = fad;
      ri = idx;
      nre++;
    end
    if (fwe) begin
      wd = fwd;
      nwe++;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
  initial begin
    seed_v = $urandom(32'h8666);
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 28; i += 4) begin
      rd(8'(i), v, r);
      chk("reset value", 32'h0000_0000, v);
    end
    rd(8'h40, v, r);
    chk("unmapped resp", 32'(sbns_pkg::RESP_SLVERR), 32'(r));
    wr(8'h40, 32'h0000_0001);
    chk("unmapped wr resp", 32'(sbns_pkg::RESP_SLVERR), 32'(wbr));
    repeat (48) begin
      k = $urandom % 4;
      {d, a, ext, bk, fa, w, x, fl} = 36'($urandom) ^ 36'($urandom << 4);
      opc = k < 2 ? 6'h16 : (k == 2 ? 6'h0E : 6'h3F);
      wr(sbns_pkg::OFS_CTRL, 32'(ext));
      wr(sbns_pkg::OFS_WREG, 32'(w));
      wr(sbns_pkg::OFS_FLAGS, 32'(fl));
      wr(sbns_pkg::OFS_BANK, 32'(bk));
      frd <= x;
      nre = 0;
      nwe = 0;
      wr(sbns_pkg::OFS_INSTR, 32'({opc, d, a, fa}));
      chk("instr wr resp", 32'(sbns_pkg::RESP_OKAY), 32'(wbr));
      n = 0;
      do rd(sbns_pkg::OFS_STAT, st, r); while (st[0] && n++ < 50);
      chk("busy", 32'h0000_0000, 32'(st[0]));
      // borrow is the inverted carry
      bo = !fl[0];
      dif = x - w - bo;
      dh = x[3:0] - w[3:0] - bo;
      res = k < 2 ? dif[7:0] : {x[3:0], x[7:4]};
      nf = k < 2 ? {res[7], x[7] != w[7] && res[7] != x[7], res == 0, dh >= 0, dif >= 0} : fl;
      ea = a ? {bk, fa} : (fa < sbns_pkg::ACCESS_SPLIT ? {4'h0, fa} : {4'hF, fa});
      eidx = !a && ext && fa <= 8'h5F;
      chk("illegal", 32'(k == 3), 32'(st[1]));
      chk("file reads", 32'(k < 3), 32'(nre));
      chk("file writes", 32'(k < 3 && d), 32'(nwe));
      if (k < 3) begin
        chk("file addr", 32'(ea), 32'(ra));
        chk("idx mode", 32'(eidx), 32'(ri));
        if (d) chk("file data", 32'(res), 32'(wd));
        rd(sbns_pkg::OFS_RESULT, v, r);
        chk("result", 32'(res), v);
      end
      rd(sbns_pkg::OFS_WREG, v, r);
      chk("wreg", 32'(d || k == 3 ? w : res), v);
      rd(sbns_pkg::OFS_FLAGS, v, r);
      chk("flags", 32'(nf), v);
      if (k == 3) wr(sbns_pkg::OFS_STAT, 32'h0000_0002);
    end
    report_and_stop;
  end
endmodule
